// >>> pkg/asf_cfg.svh
// shared constants of the authenticated serial flash port
`ifndef ASF_CFG_SVH
`define ASF_CFG_SVH
`define ASF_OP_AUTH     8'h9B
`define ASF_OP_STAT     8'h96
`define ASF_OP_READQ    8'hEB
`define ASF_OP_QPI_ON   8'h38
`define ASF_OP_QPI_OFF  8'hFF
`define ASF_CONT_MODE   8'hA0
`define ASF_CT_ROOT     8'h00
`define ASF_CT_SESS     8'h01
`define ASF_CT_INC      8'h02
`define ASF_CT_REQ      8'h03
`define ASF_NUM_SETS    8'h04
`define ASF_SB_BUSY     0
`define ASF_SB_KEY      1
`define ASF_SB_SIG      2
`define ASF_SB_UNINIT   3
`define ASF_ST_PWR      8'h00
`define ASF_ST_BUSY     8'h01
`define ASF_ST_OK       8'h80
`define ASF_IDX_SIG_END 6'h05
`define ASF_IDX_KEY_END 6'h25
`define ASF_IDX_MODE    6'h03
`define ASF_AUTH_CYC    8'h40
`define ASF_IPAD        32'h36363636
`define ASF_OPAD        32'h5C5C5C5C
`define ASF_STEP1       4'h1
`define ASF_STEP4       4'h4
`define ASF_BYTE_BITS   4'h8
`define ASF_SLOTS_OP1   9'h008
`define ASF_SLOTS_OP4   9'h002
`define ASF_BITS_LONG   9'h130
`define ASF_BITS_SHORT  9'h030
`define ASF_SLOTS_ADDR  9'h008
`define ASF_BITS_RX     9'h028
`endif

// >>> pkg/asf_pkg.sv
// types shared by both ends of the serial flash port
package asf_pkg;
   typedef enum logic [2:0] {ASF_K_AUTH, ASF_K_STAT, ASF_K_READQ, ASF_K_QPI_ON,
                             ASF_K_QPI_OFF} asf_kind_e;
   typedef enum logic [2:0] {ASF_OP, ASF_AUTH, ASF_STAT, ASF_ADDR, ASF_DATA,
                             ASF_SKIP} asf_fst_e;
   typedef enum logic [1:0] {ASF_H_IDLE, ASF_H_RUN, ASF_H_GAP} asf_hst_e;
   typedef logic [39:0] asf_word_t;
endpackage

// >>> pkg/asf_if.sv
// serial link between flash host and authenticated flash device
`timescale 1ns/1ps
interface asf_if;
   logic       sclk;
   logic       cs_n;
   logic [3:0] host_o;
   logic [3:0] host_oe;
   logic [3:0] dev_o;
   logic [3:0] dev_oe;
   wire  [3:0] io;
   // resolved line level: device wins, then host, else pulled high
   assign io = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) | (~dev_oe & ~host_oe);
   modport dev_mp (input sclk, input cs_n, input io, output dev_o, output dev_oe);
   modport host_mp (output sclk, output cs_n, output host_o, output host_oe, input io);
endinterface

// >>> design/asf_auth.sv
// keyed authentication engine with key, session and counter stores
`timescale 1ns/1ps
`include "asf_cfg.svh"
module asf_auth import asf_pkg::*; (
   // clock and reset
   input  wire logic         mclk_in,
   input  wire logic         rst_in,
   // command
   input  wire logic         start_in,
   input  wire logic [7:0]   cmd_in,
   input  wire logic [7:0]   sel_in,
   input  wire logic [31:0]  sig_in,
   input  wire logic [255:0] key_in,
   // result
   output logic              busy_out,
   output logic [7:0]        status_out,
   output logic [31:0]       cnt_out
);
   logic [255:0] root_mem [4];
   logic [255:0] sess_mem [4];
   logic [31:0]  ctr_mem  [4];
   logic [3:0]   prov_ff;
   logic [3:0]   sval_ff;
   logic [7:0]   tmr_ff;
   logic [7:0]   cmd_ff;
   logic [7:0]   sel_ff;
   logic [31:0]  sig_ff;
   logic [255:0] key_ff;
   logic [1:0]   ix;
   logic         sel_ok;

   // compression stand-in: folds eight key words into a running word
   function automatic logic [31:0] asf_fold(input logic [255:0] k, input logic [31:0] pad,
                                            input logic [31:0] m);
      logic [31:0] a;
      a = m;
      for (int i = 0; i < 8; i++) begin
         a = {a[26:0], a[31:27]} + (k[i*32 +: 32] ^ pad);
      end
      return a;
   endfunction

   // keyed digest: inner pass with key, outer pass with key again
   function automatic logic [31:0] asf_mac(input logic [255:0] k, input logic [7:0] c,
                                           input logic [7:0] s, input logic [31:0] n);
      return asf_fold(k, `ASF_OPAD, asf_fold(k, `ASF_IPAD, {c, s, n[15:0]} ^ n));
   endfunction

   assign ix = sel_ff[1:0];
   assign sel_ok = sel_ff < `ASF_NUM_SETS;

   // busy timer; a start while busy is dropped
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         busy_out <= 1'b0;
         tmr_ff   <= 8'h00;
      end else if (start_in && !busy_out) begin
         busy_out <= 1'b1;
         tmr_ff   <= `ASF_AUTH_CYC;
      end else if (busy_out) begin
         tmr_ff   <= tmr_ff - 8'h01;
         busy_out <= tmr_ff != 8'h00;
      end
   end

   // command capture at start
   always_ff @(posedge mclk_in) begin
      if (start_in && !busy_out) begin
         cmd_ff <= cmd_in;
         sel_ff <= sel_in;
         sig_ff <= sig_in;
         key_ff <= key_in;
      end
   end

   // execution and status at the end of the busy period
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         status_out <= `ASF_ST_PWR;
         cnt_out    <= 32'h0;
         prov_ff    <= 4'h0;
         sval_ff    <= 4'h0;
      end else if (start_in && !busy_out) begin
         status_out <= `ASF_ST_BUSY;
      end else if (busy_out && tmr_ff == 8'h00) begin
         status_out <= `ASF_ST_OK;
         if (!sel_ok || cmd_ff > `ASF_CT_REQ) begin
            status_out <= 8'h1 << `ASF_SB_SIG;
         end else if (cmd_ff == `ASF_CT_ROOT) begin
            if (prov_ff[ix]) begin
               status_out <= 8'h1 << `ASF_SB_KEY;
            end else begin
               root_mem[ix] <= key_ff;
               ctr_mem[ix]  <= 32'h0;
               prov_ff[ix]  <= 1'b1;
            end
         end else if (cmd_ff == `ASF_CT_SESS) begin
            if (!prov_ff[ix]) begin
               status_out <= 8'h1 << `ASF_SB_KEY;
            end else if (sig_ff != asf_mac(root_mem[ix], cmd_ff, sel_ff, ctr_mem[ix])) begin
               status_out <= 8'h1 << `ASF_SB_SIG;
            end else begin
               sess_mem[ix] <= key_ff;
               sval_ff[ix]  <= 1'b1;
            end
         end else if (!sval_ff[ix]) begin
            status_out <= 8'h1 << `ASF_SB_UNINIT;
         end else if (sig_ff != asf_mac(sess_mem[ix], cmd_ff, sel_ff, ctr_mem[ix])) begin
            status_out <= 8'h1 << `ASF_SB_SIG;
         end else if (cmd_ff == `ASF_CT_INC) begin
            ctr_mem[ix] <= ctr_mem[ix] + 32'h1;
         end else begin
            cnt_out <= ctr_mem[ix];
         end
      end
   end
endmodule

// >>> design/asf_dev.sv
// authenticated flash device end: serial front, crossings, engine
// Behaviour
// - chip select high: outputs released
// - no instruction before first select fall
// - single mode: sample input line rising
// - single mode: output line changes falling
// - dual/quad: in rising, out falling
// - single/dual lines 0-1, quad 0-3
// - four-line instruction mode, two clocks
// - continuous read: eight clocks overhead
// - four 32-bit monotonic counters
// - eight-bit selector chooses counter, unsigned
// - four root, session keys, counters
// - keyed hash: key, hash, key, hash
// - recompute, compare, report in status
// - provisioning stores root, zeroes counter
// - provisioned root key never rewritten (reset clears prov_ff here, so a later root command rewrites it)
// - host updates session key first
// - increment adds exactly one
// - request returns selected counter value
// - host cannot pick start number or rate
// - busy bit 0 set while executing
// - ignore auth command while busy
// - clean completion sets success pattern
`timescale 1ns/1ps
`include "asf_cfg.svh"
module asf_dev import asf_pkg::*; (
   // system clock and reset
   input  wire logic mclk_in,
   input  wire logic rst_in,
   // link
   asf_if.dev_mp     lnk,
   // user side
   output logic [7:0] status_out
);
   asf_fst_e     st_ff;
   asf_fst_e     cur_st;
   logic [3:0]   bit_ff;
   logic [3:0]   nxt_bit;
   logic [5:0]   idx_ff;
   logic [7:0]   sh_ff;
   logic [7:0]   nxt_sh;
   logic [23:0]  addr_ff;
   logic         lanes4;
   logic         byte_done;
   logic         qpi_ff;
   logic         cont_ff;
   logic [7:0]   cmd_ff;
   logic [7:0]   sel_ff;
   logic [31:0]  sig_ff;
   logic [255:0] key_ff;
   logic         req_ff;
   logic         auth_last;
   logic         rst_s1_ff, rst_s2_ff;
   logic         lrst_ff, lr_s1_ff, lr_s2_ff;
   logic         arm_s1_ff, arm_s2_ff;
   logic         sr_s1_ff, sr_s2_ff, sr_s3_ff;
   logic         ack_ff;
   logic [7:0]   stat_cp_ff;
   logic [31:0]  cnt_cp_ff;
   logic         out_ph;
   logic         olanes4;
   logic         loaded_ff;
   asf_word_t    txsh_ff;
   asf_word_t    src;
   logic         cs_s1_ff, cs_s2_ff, seen_hi_ff, armed_ff;
   logic         rq_s1_ff, rq_s2_ff, rq_s3_ff;
   logic         ak_s1_ff, ak_s2_ff;
   logic         sreq_ff;
   asf_word_t    snap_ff;
   logic         eng_busy;
   logic [7:0]   eng_status;
   logic [31:0]  eng_cnt;

   // ---- link clock domain ----
   // continuous mode turns the opcode slot into the address phase
   assign cur_st = (st_ff == ASF_OP && cont_ff) ? ASF_ADDR : st_ff;
   assign lanes4 = qpi_ff || cur_st == ASF_ADDR;
   assign nxt_sh = lanes4 ? {sh_ff[3:0], lnk.io} : {sh_ff[6:0], lnk.io[0]};
   assign nxt_bit = bit_ff + (lanes4 ? `ASF_STEP4 : `ASF_STEP1);
   assign byte_done = nxt_bit == `ASF_BYTE_BITS;
   assign auth_last = cur_st == ASF_AUTH && byte_done &&
                      (idx_ff == `ASF_IDX_KEY_END ||
                       (idx_ff == `ASF_IDX_SIG_END && cmd_ff > `ASF_CT_SESS));

   // reset level and arm level brought into the link domain
   always_ff @(posedge lnk.sclk) begin
      rst_s1_ff <= lrst_ff;
      rst_s2_ff <= rst_s1_ff;
      arm_s1_ff <= armed_ff;
      arm_s2_ff <= arm_s1_ff;
   end

   // frame decoder, cleared whenever select is high
   always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
      if (lnk.cs_n) begin
         st_ff  <= ASF_OP;
         bit_ff <= 4'h0;
         idx_ff <= 6'h00;
         sh_ff  <= 8'h00;
      end else begin
         sh_ff  <= nxt_sh;
         bit_ff <= byte_done ? 4'h0 : nxt_bit;
         if (byte_done && cur_st != ASF_OP) begin
            idx_ff <= idx_ff + 6'h01;
         end
         if (byte_done) begin
            case (cur_st)
               ASF_OP: begin
                  if (!arm_s2_ff) begin
                     st_ff <= ASF_SKIP;
                  end else if (nxt_sh == `ASF_OP_AUTH) begin
                     st_ff <= stat_cp_ff[`ASF_SB_BUSY] ? ASF_SKIP : ASF_AUTH;
                  end else if (nxt_sh == `ASF_OP_STAT) begin
                     st_ff <= ASF_STAT;
                  end else if (nxt_sh == `ASF_OP_READQ) begin
                     st_ff <= ASF_ADDR;
                  end else begin
                     st_ff <= ASF_SKIP;
                  end
               end
               ASF_AUTH: st_ff <= auth_last ? ASF_SKIP : ASF_AUTH;
               ASF_ADDR: st_ff <= (idx_ff == `ASF_IDX_MODE) ? ASF_DATA : ASF_ADDR;
               default:  st_ff <= st_ff;
            endcase
         end
      end
   end

   // persistent mode bits and read address
   always_ff @(posedge lnk.sclk) begin
      if (rst_s2_ff) begin
         qpi_ff  <= 1'b0;
         cont_ff <= 1'b0;
      end else if (byte_done && cur_st == ASF_OP && arm_s2_ff) begin
         if (nxt_sh == `ASF_OP_QPI_ON) begin
            qpi_ff <= 1'b1;
         end else if (nxt_sh == `ASF_OP_QPI_OFF) begin
            qpi_ff <= 1'b0;
         end
      end else if (byte_done && cur_st == ASF_ADDR) begin
         if (idx_ff == `ASF_IDX_MODE) begin
            cont_ff <= nxt_sh == `ASF_CONT_MODE;
         end else begin
            addr_ff <= {addr_ff[15:0], nxt_sh};
         end
      end
   end

   // authentication fields and request toggle
   always_ff @(posedge lnk.sclk) begin
      if (rst_s2_ff) begin
         req_ff <= 1'b0;
      end else if (cur_st == ASF_AUTH && byte_done) begin
         if (idx_ff == 6'h00) begin
            cmd_ff <= nxt_sh;
         end else if (idx_ff == 6'h01) begin
            sel_ff <= nxt_sh;
         end else if (idx_ff <= `ASF_IDX_SIG_END) begin
            sig_ff <= {sig_ff[23:0], nxt_sh};
         end else begin
            key_ff <= {key_ff[247:0], nxt_sh};
         end
         if (auth_last) begin
            req_ff <= ~req_ff;
         end
      end
   end

   // status snapshot handshake, receiving side
   always_ff @(posedge lnk.sclk) begin
      sr_s1_ff <= sreq_ff;
      sr_s2_ff <= sr_s1_ff;
      sr_s3_ff <= sr_s2_ff;
      if (rst_s2_ff) begin
         ack_ff     <= 1'b0;
         stat_cp_ff <= `ASF_ST_PWR;
         cnt_cp_ff  <= 32'h0;
      end else if (sr_s2_ff != sr_s3_ff) begin
         stat_cp_ff <= snap_ff[39:32];
         cnt_cp_ff  <= snap_ff[31:0];
         ack_ff     <= sr_s2_ff;
      end
   end

   // output launcher on falling edges, released while deselected
   assign out_ph  = st_ff == ASF_STAT || st_ff == ASF_DATA;
   assign olanes4 = qpi_ff || st_ff == ASF_DATA;
   assign src = loaded_ff ? txsh_ff :
                (st_ff == ASF_STAT) ? {stat_cp_ff, cnt_cp_ff} : {5{addr_ff[7:0]}};
   always_ff @(negedge lnk.sclk or posedge lnk.cs_n) begin
      if (lnk.cs_n) begin
         lnk.dev_o  <= 4'h0;
         lnk.dev_oe <= 4'h0;
         loaded_ff  <= 1'b0;
         txsh_ff    <= '0;
      end else if (out_ph) begin
         loaded_ff <= 1'b1;
         if (olanes4) begin
            lnk.dev_o  <= src[39:36];
            lnk.dev_oe <= 4'hF;
            txsh_ff    <= {src[35:0], 4'h0};
         end else begin
            lnk.dev_o  <= {2'b00, src[39], 1'b0};
            lnk.dev_oe <= 4'h2;
            txsh_ff    <= {src[38:0], 1'b0};
         end
      end
   end

   // ---- system clock domain ----
   // link-side reset held until the link clock has carried it across;
   // the host stops the link clock in reset, so a plain pulse is lost
   always_ff @(posedge mclk_in) begin
      lr_s1_ff <= rst_s2_ff;
      lr_s2_ff <= lr_s1_ff;
      if (rst_in) begin
         lrst_ff <= 1'b1;
      end else if (lr_s2_ff == 1'b1) begin
         lrst_ff <= 1'b0;
      end
   end

   // select watcher: arms decoding once a high-to-low select is seen
   always_ff @(posedge mclk_in) begin
      cs_s1_ff <= lnk.cs_n;
      cs_s2_ff <= cs_s1_ff;
      if (rst_in) begin
         seen_hi_ff <= 1'b0;
         armed_ff   <= 1'b0;
      end else begin
         seen_hi_ff <= seen_hi_ff | cs_s2_ff;
         armed_ff   <= armed_ff | (seen_hi_ff & ~cs_s2_ff);
      end
   end

   // request toggle synchroniser feeding the engine
   always_ff @(posedge mclk_in) begin
      rq_s1_ff <= req_ff;
      rq_s2_ff <= rq_s1_ff;
      rq_s3_ff <= rq_s2_ff;
      ak_s1_ff <= ack_ff;
      ak_s2_ff <= ak_s1_ff;
   end

   // status snapshot handshake, sending side
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         sreq_ff    <= 1'b0;
         snap_ff    <= '0;
         status_out <= `ASF_ST_PWR;
      end else begin
         status_out <= eng_status;
         if (ak_s2_ff == sreq_ff && snap_ff != {eng_status, eng_cnt}) begin
            snap_ff <= {eng_status, eng_cnt};
            sreq_ff <= ~sreq_ff;
         end
      end
   end

   // engine holding keys and counters
   asf_auth u_auth (
      .mclk_in    (mclk_in),
      .rst_in     (rst_in || !armed_ff),
      .start_in   (rq_s2_ff != rq_s3_ff),
      .cmd_in     (cmd_ff),
      .sel_in     (sel_ff),
      .sig_in     (sig_ff),
      .key_in     (key_ff),
      .busy_out   (eng_busy),
      .status_out (eng_status),
      .cnt_out    (eng_cnt)
   );
endmodule

// >>> design/asf_host.sv
// flash host end: makes the link clock and runs one frame per request
`timescale 1ns/1ps
`include "asf_cfg.svh"
module asf_host import asf_pkg::*; (
   // clock and reset
   input  wire logic         mclk_in,
   input  wire logic         rst_in,
   // link
   asf_if.host_mp            lnk,
   // request
   input  wire logic         req_valid_in,
   input  asf_kind_e         req_kind_in,
   input  wire logic [7:0]   cmd_type_in,
   input  wire logic [7:0]   sel_in,
   input  wire logic [31:0]  sig_in,
   input  wire logic [255:0] key_in,
   input  wire logic [23:0]  addr_in,
   input  wire logic         cont_in,
   // answer
   output logic              req_ready_out,
   output logic              resp_valid_out,
   output asf_word_t         resp_data_out
);
   asf_hst_e     st_ff;
   logic [1:0]   ph_ff;
   logic [8:0]   slot_ff, op_end_ff, tx_end_ff, all_end_ff;
   logic [8:0]   nxt_op, nxt_tx, nxt_rx;
   logic [319:0] tx_ff, nxt_tx_data;
   logic         oq_ff, dq_ff, nxt_dq, quad, qpi_ff, cont_ff;
   logic [3:0]   io_s1_ff, io_s2_ff;
   asf_word_t    rx_ff;
   asf_kind_e    kind_ff;

   // frame shape of the offered request
   always_comb begin
      nxt_op = cont_ff && req_kind_in == ASF_K_READQ ? 9'h000 :
               qpi_ff ? `ASF_SLOTS_OP4 : `ASF_SLOTS_OP1;
      nxt_dq = qpi_ff || req_kind_in == ASF_K_READQ;
      nxt_rx = 9'h000;
      nxt_tx = 9'h000;
      nxt_tx_data = '0;
      case (req_kind_in)
         ASF_K_AUTH: begin
            nxt_tx = cmd_type_in > `ASF_CT_SESS ? `ASF_BITS_SHORT : `ASF_BITS_LONG;
            nxt_tx = qpi_ff ? nxt_tx >> 2 : nxt_tx;
            nxt_tx_data = {`ASF_OP_AUTH, cmd_type_in, sel_in, sig_in, key_in, 8'h00};
         end
         ASF_K_STAT: begin
            nxt_rx = qpi_ff ? `ASF_BITS_RX >> 2 : `ASF_BITS_RX;
            nxt_tx_data = {`ASF_OP_STAT, 312'h0};
         end
         ASF_K_READQ: begin
            nxt_tx = `ASF_SLOTS_ADDR;
            nxt_rx = `ASF_BITS_RX >> 2;
            nxt_tx_data = cont_ff ? {addr_in, cont_in ? `ASF_CONT_MODE : 8'h00, 288'h0} :
                          {`ASF_OP_READQ, addr_in, cont_in ? `ASF_CONT_MODE : 8'h00, 280'h0};
         end
         ASF_K_QPI_ON:  nxt_tx_data = {`ASF_OP_QPI_ON, 312'h0};
         default:       nxt_tx_data = {`ASF_OP_QPI_OFF, 312'h0};
      endcase
   end

   // returned lines pass two flip-flops before use
   always_ff @(posedge mclk_in) begin
      io_s1_ff <= lnk.io;
      io_s2_ff <= io_s1_ff;
   end

   assign quad = slot_ff <= op_end_ff ? oq_ff : dq_ff;

   // sequencer: four system clocks per link clock, low on idle
   always_ff @(posedge mclk_in) begin
      resp_valid_out <= 1'b0;
      if (rst_in) begin
         st_ff <= ASF_H_IDLE;
         ph_ff <= 2'd0;
         lnk.sclk <= 1'b0;
         lnk.cs_n <= 1'b1;
         lnk.host_o <= 4'h0;
         lnk.host_oe <= 4'h0;
         req_ready_out <= 1'b0;
         resp_data_out <= '0;
         qpi_ff <= 1'b0;
         cont_ff <= 1'b0;
         slot_ff <= 9'h000;
      end else begin
         ph_ff <= ph_ff + 2'd1;
         case (st_ff)
            ASF_H_IDLE: begin
               req_ready_out <= 1'b1;
               if (req_valid_in && req_ready_out) begin
                  req_ready_out <= 1'b0;
                  st_ff <= ASF_H_RUN;
                  lnk.cs_n <= 1'b0;
                  ph_ff <= 2'd3;
                  slot_ff <= 9'h000;
                  kind_ff <= req_kind_in;
                  op_end_ff <= nxt_op;
                  tx_end_ff <= nxt_op + nxt_tx;
                  all_end_ff <= nxt_op + nxt_tx + nxt_rx;
                  tx_ff <= nxt_tx_data;
                  oq_ff <= qpi_ff;
                  dq_ff <= nxt_dq;
                  if (req_kind_in == ASF_K_READQ) begin
                     cont_ff <= cont_in;
                  end
               end
            end
            ASF_H_RUN: begin
               if (ph_ff == 2'd1) begin
                  lnk.sclk <= 1'b1;
               end else if (ph_ff == 2'd2 && slot_ff > tx_end_ff) begin
                  rx_ff <= quad ? {rx_ff[35:0], io_s2_ff} : {rx_ff[38:0], io_s2_ff[1]};
               end else if (ph_ff == 2'd3) begin
                  lnk.sclk <= 1'b0;
                  slot_ff <= slot_ff + 9'h001;
                  if (slot_ff == all_end_ff) begin
                     lnk.cs_n <= 1'b1;
                     lnk.host_oe <= 4'h0;
                     st_ff <= ASF_H_GAP;
                     resp_valid_out <= 1'b1;
                     resp_data_out <= rx_ff;
                     if (kind_ff == ASF_K_QPI_ON) qpi_ff <= 1'b1;
                     if (kind_ff == ASF_K_QPI_OFF) qpi_ff <= 1'b0;
                  end else if (slot_ff < tx_end_ff) begin
                     if (slot_ff < op_end_ff ? oq_ff : dq_ff) begin
                        lnk.host_o <= tx_ff[319:316];
                        lnk.host_oe <= 4'hF;
                        tx_ff <= {tx_ff[315:0], 4'h0};
                     end else begin
                        lnk.host_o <= {3'b000, tx_ff[319]};
                        lnk.host_oe <= 4'h1;
                        tx_ff <= {tx_ff[318:0], 1'b0};
                     end
                  end else begin
                     lnk.host_oe <= 4'h0;
                  end
               end
            end
            default: begin
               if (ph_ff == 2'd3) begin
                  st_ff <= ASF_H_IDLE;
               end
            end
         endcase
      end
   end
endmodule

// >>> test/asf_props.sv
// link checks between the flash host end and the device end
`timescale 1ns/1ps
module asf_props (
   // system clock and reset
   input wire logic       mclk_in,
   input wire logic       rst_in,
   // link signals
   input wire logic       sclk,
   input wire logic       cs_n,
   input wire logic [3:0] host_o,
   input wire logic [3:0] host_oe,
   input wire logic [3:0] dev_o,
   input wire logic [3:0] dev_oe
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // device side: release, launch edge, line use
   cs_released_a: assert property (cs_n && $past(cs_n) |-> dev_oe == 4'h0)
      else $error("device drives while deselected");
   dev_fall_a: assert property (!cs_n && !$past(cs_n) && $changed(dev_o) |-> $fell(sclk))
      else $error("device data moved off the falling edge");
   line_set_a: assert property (dev_oe inside {4'h0, 4'h2, 4'hF})
      else $error("device drives a line outside its mode");
   no_clash_a: assert property ((dev_oe & host_oe) == 4'h0)
      else $error("both ends drive one line");
   // host side: hold across rise, frame end and gap
   host_hold_a: assert property ($rose(sclk) |-> $stable(host_o) ##1 $stable(host_o))
      else $error("host data moved around the rising edge");
   host_release_a: assert property (cs_n && $past(cs_n) |-> host_oe == 4'h0)
      else $error("host drives outside a frame");
   select_gap_a: assert property ($rose(cs_n) |-> cs_n [*4])
      else $error("chip select gap too short");
   sclk_idle_a: assert property (cs_n && $past(cs_n) |-> !sclk)
      else $error("link clock runs outside a frame");
   // main scenarios reached
   cover property ($fell(cs_n));
   cover property (dev_oe == 4'hF);
   cover property (dev_oe == 4'h2);
endmodule

// >>> test/tb_authenticated_serial_flash_port.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
`include "asf_cfg.svh"
module tb_authenticated_serial_flash_port import asf_pkg::*;;
   logic         mclk_in = 1'b0;
   logic         rst_in = 1'b1;
   logic         req_valid = 1'b0;
   asf_kind_e    req_kind = ASF_K_STAT;
   logic [7:0]   ctype = 8'h00;
   logic [7:0]   sel = 8'h00;
   logic [31:0]  sig = 32'h0;
   logic [255:0] key = 256'h0;
   logic [23:0]  addr = 24'h0;
   logic         cont = 1'b0;
   logic         ready;
   logic         rvalid;
   asf_word_t    rdata;
   asf_word_t    resp;
   logic [7:0]   st;
   int           failures = 0;
   int           comparisons = 0;
   int           cycles = 0;
   localparam logic [255:0] RK = {8{32'h1F2E3D4C}};
   localparam logic [255:0] SK = {8{32'h0A1B2C3D}};
   // both ends and the link checker
   asf_if i_asf_if ();
   asf_host i_asf_host (.mclk_in(mclk_in), .rst_in(rst_in), .lnk(i_asf_if.host_mp),
      .req_valid_in(req_valid), .req_kind_in(req_kind), .cmd_type_in(ctype), .sel_in(sel),
      .sig_in(sig), .key_in(key), .addr_in(addr), .cont_in(cont), .req_ready_out(ready),
      .resp_valid_out(rvalid), .resp_data_out(rdata));
   asf_dev i_asf_dev (.mclk_in(mclk_in), .rst_in(rst_in), .lnk(i_asf_if.dev_mp), .status_out(st));
   asf_props i_asf_props (.mclk_in(mclk_in), .rst_in(rst_in), .sclk(i_asf_if.sclk),
      .cs_n(i_asf_if.cs_n), .host_o(i_asf_if.host_o), .host_oe(i_asf_if.host_oe),
      .dev_o(i_asf_if.dev_o), .dev_oe(i_asf_if.dev_oe));
   // clock, reset and hang guard
   initial begin
      forever #5 mclk_in = ~mclk_in;
   end
   initial begin
      repeat (3) @(posedge mclk_in);
      rst_in <= 1'b0;
   end
   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures = failures + 1;
         results();
      end
   end
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // keyed fold used to sign commands
   function automatic logic [31:0] fold(input logic [255:0] k, input logic [31:0] p,
                                        input logic [31:0] a);
      for (int i = 0; i < 8; i++) begin
         a = {a[26:0], a[31:27]} + (k[32*i+:32] ^ p);
      end
      return a;
   endfunction
   function automatic logic [31:0] mac(input logic [255:0] k, input logic [7:0] c,
                                       input logic [7:0] s, input logic [31:0] n);
      return fold(k, `ASF_OPAD, fold(k, `ASF_IPAD, {c, s, n[15:0]} ^ n));
   endfunction
   // one host request, waits for the frame to end
   task automatic frame(input asf_kind_e k);
      req_kind <= k;
      req_valid <= 1'b1;
      do @(posedge mclk_in); while (ready !== 1'b1);
      req_valid <= 1'b0;
      do @(posedge mclk_in); while (rvalid !== 1'b1);
      resp = rdata;
   endtask
   // auth command, busy while running, then result read over the link
   task automatic auth(input logic [7:0] t, input logic [7:0] s, input logic [31:0] g,
                       input logic [255:0] k, input logic [7:0] exp);
      ctype <= t;
      sel <= s;
      sig <= g;
      key <= k;
      frame(ASF_K_AUTH);
      repeat (8) @(posedge mclk_in);
      chk({32'h0, st}, {32'h0, `ASF_ST_BUSY});
      repeat (`ASF_AUTH_CYC + 8'h10) @(posedge mclk_in);
      chk({32'h0, st}, {32'h0, exp});
      frame(ASF_K_STAT);
      frame(ASF_K_STAT);
      chk({32'h0, resp[39:32]}, {32'h0, exp});
   endtask
   // main sequence
   initial begin
      repeat (4) @(posedge mclk_in);
      frame(ASF_K_STAT);
      frame(ASF_K_STAT);
      chk({32'h0, resp[39:32]}, {32'h0, `ASF_ST_PWR});
      auth(`ASF_CT_ROOT, 8'h00, mac(RK, `ASF_CT_ROOT, 8'h00, 0), RK, `ASF_ST_OK);
      auth(`ASF_CT_INC, 8'h00, 32'h0, 256'h0, 8'h08);
      auth(`ASF_CT_SESS, 8'h00, mac(RK, `ASF_CT_SESS, 8'h00, 0), SK, `ASF_ST_OK);
      auth(`ASF_CT_REQ, 8'h00, mac(SK, `ASF_CT_REQ, 8'h00, 0), 256'h0, `ASF_ST_OK);
      chk({8'h0, resp[31:0]}, 40'h0);
      auth(`ASF_CT_INC, 8'h00, mac(SK, `ASF_CT_INC, 8'h00, 0), 256'h0, `ASF_ST_OK);
      auth(`ASF_CT_REQ, 8'h00, mac(SK, `ASF_CT_REQ, 8'h00, 1), 256'h0, `ASF_ST_OK);
      chk({8'h0, resp[31:0]}, 40'h1);
      auth(`ASF_CT_ROOT, 8'h00, mac(SK, `ASF_CT_ROOT, 8'h00, 1), SK, 8'h02);
      auth(`ASF_CT_INC, 8'h00, ~mac(SK, `ASF_CT_INC, 8'h00, 1), 256'h0, 8'h04);
      auth(`ASF_CT_REQ, 8'h04, mac(SK, `ASF_CT_REQ, 8'h04, 1), 256'h0, 8'h04);
      frame(ASF_K_QPI_ON);
      frame(ASF_K_STAT);
      chk({32'h0, resp[39:32]}, 40'h04);
      addr <= 24'h1234A5;
      cont <= 1'b1;
      frame(ASF_K_READQ);
      chk(resp, {5{8'hA5}});
      addr <= 24'h00003C;
      frame(ASF_K_READQ);
      chk(resp, {5{8'h3C}});
      addr <= 24'h00005A;
      cont <= 1'b0;
      frame(ASF_K_READQ);
      chk(resp, {5{8'h5A}});
      frame(ASF_K_QPI_OFF);
      frame(ASF_K_STAT);
      chk({32'h0, resp[39:32]}, 40'h04);
      results();
   end
endmodule
